// [include/link_init_pkg.sv]
// link reset and width negotiation: shared constants and helpers
// assumes a 20 MHz system clock; link pins are sampled, never used as clocks
// Contract
// R1 - cold reset starts transmitter clock at base rate
// R2 - receivers accept any incoming rate from base up
// R3 - new tx rate applies only at reset/stop
// R4 - cold reset: power-good low plus reset asserted
// R5 - warm reset keeps persistent state only
// R6 - system: reset 1 ms around power-good rise
// R7 - internal reset from reset pin or power-good low
// R8 - device may extend reset until clocks stable
// R9 - system: warm reset held at least 1 ms
// R10 - system: link-stop high 1 us before release
// R11 - system: both ends see reset within 1 us
// R12 - cold width is min of ends, cap 8
// R13 - board ties unused receiver inputs to zero
// R14 - during reset: clock toggles, control 0, pattern
// R15 - pattern 3, F or all implemented ones
// R16 - hold pattern until both control lines seen
// R17 - narrower transmitter drives all its lines one
// R18 - decode width from data sampled at release
// R19 - all-zero sample sets chain-terminal flag
// R20 - decoded width loads inbound and outbound fields
// R21 - warm keeps programmed widths, checks bit 0
// R22 - warm reset drives programmed width ones
// R23 - after both controls seen, 16 bit-times, invert
package link_init_pkg;
  localparam int CAD_W = 32;
  localparam int LINK_MHZ_RST = 200;          // documented cold-reset link rate
  localparam logic [1:0] FREQ_RST = 2'h0;     // rate code that stands for it
  localparam int HALF_BASE = 4;               // sys cycles per half period at code 0
  localparam int WIDTH_CAP = 8;
  localparam int SYNC_BIT_TIMES = 16;
  localparam int SYS_CLK_KHZ = 20000;
  localparam int T_RST_MS = 1;
  localparam int T_STOP_US = 1;
  localparam int CYC_1MS = T_RST_MS * SYS_CLK_KHZ;
  localparam int CYC_1US = (T_STOP_US * SYS_CLK_KHZ + 999) / 1000;
  localparam logic [31:0] PAT_2 = 32'h0000_0003;
  localparam logic [31:0] PAT_4 = 32'h0000_000f;

  function automatic logic [5:0] min3(input int a, input int b, input int c);
    int m;
    m = (a < b) ? a : b;
    m = (m < c) ? m : c;
    return 6'(m);
  endfunction

  function automatic logic [31:0] ones_mask(input logic [5:0] n);
    return (n >= 6'h20) ? 32'hffff_ffff : ((32'h1 << n) - 32'h1);
  endfunction

  // narrow ends advertise their own width; wide ends drive every tx bit high
  function automatic logic [31:0] adv_pattern(input int rxW, input int txW);
    logic [5:0] n;
    n = min3(rxW, txW, CAD_W);
    return (n < 6'(WIDTH_CAP)) ? ones_mask(n) : ones_mask(6'(txW));
  endfunction
endpackage

// [include/link_if.sv]
// link pins between the device end and the peer/system end
// the open-drain reset wire is resolved here from both ends' enables
`timescale 1ns/1ps
interface link_if;
  logic devClk;
  logic devCtl;
  logic [31:0] devCad;
  logic peerClk;
  logic peerCtl;
  logic [31:0] peerCad;
  logic devRstOut;
  logic devRstOeN;
  logic sysRstOut;
  logic sysRstOeN;
  logic resetN;
  logic powerGood;
  logic linkStopN;

  // wired-and reset line with pull-up; enable is low while driving
  assign resetN = ~((~devRstOeN & ~devRstOut) | (~sysRstOeN & ~sysRstOut));

  modport dev_mp (
    output devClk, devCtl, devCad, devRstOut, devRstOeN,
    input peerClk, peerCtl, peerCad, resetN, powerGood, linkStopN
  );
  modport peer_mp (
    output peerClk, peerCtl, peerCad, sysRstOut, sysRstOeN, powerGood, linkStopN,
    input devClk, devCtl, devCad, resetN
  );
endinterface

// [rtl/link_dev_end.sv]
// documented device end: reset classification, width advertising and decode
// assumes link pins arrive asynchronously and are sampled by sys_clk
`timescale 1ns/1ps
module link_dev_end #(
  parameter int TX_W = 8,
  parameter int RX_W = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [5:0] progInWidth,
  input wire logic [5:0] progOutWidth,
  input wire logic [1:0] progFreq,
  input wire logic clkStable,
  input wire logic errEvent,
  output logic [5:0] inWidth,
  output logic [5:0] outWidth,
  output logic [1:0] freqActive,
  output logic chainTerminal,
  output logic persistErr,
  output logic unitIdAssign,
  output logic initDone,
  link_if.dev_mp link
);
  if (!(TX_W inside {2, 4, 8, 16, 32}) || !(RX_W inside {2, 4, 8, 16, 32})) begin : g_chk
    $error("link_dev_end: widths must be 2, 4, 8, 16 or 32");
  end

  typedef enum logic [1:0] {ST_RESET, ST_CTL, ST_SYNC, ST_DONE} dev_state_e;

  // cold decode of the sampled incoming lines
  function automatic logic [5:0] decode_width(input logic [31:0] cad);
    if (cad == link_init_pkg::PAT_2) begin
      return 6'h02;
    end else if (cad == link_init_pkg::PAT_4) begin
      return link_init_pkg::min3(4, RX_W, TX_W);
    end else if (cad[7:0] == 8'hff) begin
      return link_init_pkg::min3(link_init_pkg::WIDTH_CAP, RX_W, TX_W);
    end else begin
      return 6'h02; // unrecognised pattern: fall back to the narrowest width
    end
  endfunction

  // pin synchronisers: {reset, power-good, link-stop, ctl, clk, cad}
  logic [36:0] pinS1Reg;
  logic [36:0] pinS2Reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinS1Reg <= 37'h0;
      pinS2Reg <= 37'h0;
    end else begin
      pinS1Reg <= {link.resetN, link.powerGood, link.linkStopN, link.peerCtl, link.peerClk,
                   link.peerCad};
      pinS2Reg <= pinS1Reg;
    end
  end

  logic [31:0] cadS;
  logic rxClkS;
  logic rxCtlS;
  logic stopNS;
  logic pgS;
  logic rstNS;
  logic intRst;
  assign cadS = pinS2Reg[31:0];
  assign rxClkS = pinS2Reg[32];
  assign rxCtlS = pinS2Reg[33];
  assign stopNS = pinS2Reg[34];
  assign pgS = pinS2Reg[35];
  assign rstNS = pinS2Reg[36];
  // link reset is undefined before power-good, so power-good low also resets
  assign intRst = ~rstNS | ~pgS; // [R7] [R4] [R5]

  // transmit clock divider; each toggle is one bit-time
  logic [3:0] divCnt_reg, divCnt_next;
  logic txClk_reg, txClk_next;
  logic rxClkPrev_reg, rxClkPrev_next;
  logic [3:0] halfCyc;
  logic bitTick;
  logic txRise;
  logic rxRise;
  assign halfCyc = 4'(link_init_pkg::HALF_BASE >> freqActive);
  assign bitTick = (divCnt_reg == halfCyc - 4'h1);
  assign txRise = bitTick & ~txClk_reg;
  // edge found from the second stage only; any rate the sampler resolves is taken
  assign rxRise = rxClkS & ~rxClkPrev_reg; // [R2]

  // the clock keeps toggling through reset so the peer can sample lanes
  always_comb begin
    divCnt_next = bitTick ? 4'h0 : divCnt_reg + 4'h1;
    txClk_next = bitTick ? ~txClk_reg : txClk_reg; // [R14]
    rxClkPrev_next = rxClkS;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      divCnt_reg <= 4'h0;
      txClk_reg <= 1'b0;
      rxClkPrev_reg <= 1'b0;
    end else begin
      divCnt_reg <= divCnt_next;
      txClk_reg <= txClk_next;
      rxClkPrev_reg <= rxClkPrev_next;
    end
  end

  // reset classification, width fields and link bring-up
  dev_state_e state_reg, state_next;
  logic intRstPrev_reg, intRstPrev_next;
  logic coldPend_reg, coldPend_next;
  logic peerCtlSeen_reg, peerCtlSeen_next;
  logic [4:0] bitCnt_reg, bitCnt_next;
  logic [5:0] inWidth_reg, inWidth_next;
  logic [5:0] outWidth_reg, outWidth_next;
  logic [1:0] freq_reg, freq_next;
  logic chain_reg, chain_next;
  logic persist_reg, persist_next;
  logic unitId_reg, unitId_next;
  logic done_reg, done_next;
  logic ctl_reg, ctl_next;
  logic [31:0] cad_reg, cad_next;
  logic rstOeN_reg, rstOeN_next;
  logic [31:0] resetPattern;
  logic release_;

  assign release_ = intRstPrev_reg & ~intRst;
  // cold advertises width, warm drives the current outWidth high, rest low
  assign resetPattern = coldPend_reg ? link_init_pkg::adv_pattern(RX_W, TX_W) // [R15] [R17]
                      : link_init_pkg::ones_mask(outWidth_reg); // [R22]

  always_comb begin
    state_next = state_reg;
    intRstPrev_next = intRst;
    coldPend_next = coldPend_reg;
    peerCtlSeen_next = peerCtlSeen_reg;
    bitCnt_next = bitCnt_reg;
    inWidth_next = inWidth_reg;
    outWidth_next = outWidth_reg;
    freq_next = freq_reg;
    chain_next = chain_reg;
    persist_next = persist_reg | errEvent;
    unitId_next = 1'b0;
    done_next = done_reg;
    ctl_next = ctl_reg;
    cad_next = cad_reg;
    // hold the shared reset line low while our transmit clocks settle
    rstOeN_next = ~(pgS & ~clkStable); // [R8]
    if (!pgS) begin
      coldPend_next = 1'b1; // [R4]
    end
    // rate changes wait for a reset or a link-stop disconnect
    if (intRst || !stopNS) begin
      freq_next = coldPend_reg ? link_init_pkg::FREQ_RST : progFreq; // [R1] [R3]
    end
    if (intRst) begin
      // bring-up state and lines restart on every reset; widths hold until release, error log clears on cold only
      state_next = ST_RESET;
      peerCtlSeen_next = 1'b0;
      bitCnt_next = 5'h0;
      done_next = 1'b0;
      ctl_next = 1'b0; // [R14]
      cad_next = resetPattern; // [R14]
      if (coldPend_reg) begin
        persist_next = 1'b0; // [R4] [R5]
      end
    end else if (release_) begin
      if (coldPend_reg) begin
        inWidth_next = decode_width(cadS); // [R18] [R20] [R12]
        outWidth_next = decode_width(cadS); // [R20] [R12]
        chain_next = (cadS == 32'h0000_0000); // [R19]
        unitId_next = 1'b1; // [R4]
        coldPend_next = 1'b0;
      end else begin
        inWidth_next = progInWidth; // [R21] [R12]
        outWidth_next = progOutWidth; // [R21]
        chain_next = ~cadS[0]; // [R21]
      end
    end else begin
      if (rxRise && rxCtlS) begin
        peerCtlSeen_next = 1'b1;
      end
      unique case (state_reg)
        ST_RESET: begin
          // pattern stays up until both control lines are seen high
          if (txRise && clkStable && !chain_reg) begin
            state_next = ST_CTL;
            ctl_next = 1'b1; // [R16]
          end
        end
        ST_CTL: begin
          if (peerCtlSeen_reg) begin
            state_next = ST_SYNC; // [R16]
            bitCnt_next = 5'h0;
          end
        end
        ST_SYNC: begin
          if (bitTick) begin
            bitCnt_next = bitCnt_reg + 5'h1;
          end
          // invert control and data together on a rising edge
          if (txRise && bitCnt_reg >= 5'(link_init_pkg::SYNC_BIT_TIMES)) begin
            state_next = ST_DONE; // [R23]
            ctl_next = 1'b0; // [R23]
            cad_next = 32'h0000_0000; // [R23]
            done_next = 1'b1;
          end
        end
        ST_DONE: begin
          done_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= ST_RESET;
      intRstPrev_reg <= 1'b1;
      coldPend_reg <= 1'b1;
      peerCtlSeen_reg <= 1'b0;
      bitCnt_reg <= 5'h0;
      inWidth_reg <= 6'(link_init_pkg::WIDTH_CAP); // cap doubles as the pre-decode width
      outWidth_reg <= 6'(link_init_pkg::WIDTH_CAP);
      freq_reg <= link_init_pkg::FREQ_RST;
      chain_reg <= 1'b0;
      persist_reg <= 1'b0;
      unitId_reg <= 1'b0;
      done_reg <= 1'b0;
      ctl_reg <= 1'b0;
      cad_reg <= 32'h0000_0000;
      rstOeN_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      intRstPrev_reg <= intRstPrev_next;
      coldPend_reg <= coldPend_next;
      peerCtlSeen_reg <= peerCtlSeen_next;
      bitCnt_reg <= bitCnt_next;
      inWidth_reg <= inWidth_next;
      outWidth_reg <= outWidth_next;
      freq_reg <= freq_next;
      chain_reg <= chain_next;
      persist_reg <= persist_next;
      unitId_reg <= unitId_next;
      done_reg <= done_next;
      ctl_reg <= ctl_next;
      cad_reg <= cad_next;
      rstOeN_reg <= rstOeN_next;
    end
  end

  // outputs come from registers, devCad masked to TX_W; devRstOut is a constant
  assign freqActive = freq_reg;
  assign inWidth = inWidth_reg;
  assign outWidth = outWidth_reg;
  assign chainTerminal = chain_reg;
  assign persistErr = persist_reg;
  assign unitIdAssign = unitId_reg;
  assign initDone = done_reg;
  assign link.devClk = txClk_reg;
  assign link.devCtl = ctl_reg;
  assign link.devCad = cad_reg & link_init_pkg::ones_mask(6'(TX_W)); // unimplemented bits low
  assign link.devRstOut = 1'b0; // open drain: only ever pulls low
  assign link.devRstOeN = rstOeN_reg;
endmodule

// [rtl/link_peer_end.sv]
// far end: system reset source plus the peer link transmitter
// assumes the device end is joined through link_if; reset wire may be extended
`timescale 1ns/1ps
module link_peer_end #(
  parameter int TX_W = 8,
  parameter int RX_W = 8,
  parameter int RST_HOLD_CYC = link_init_pkg::CYC_1MS,
  parameter int STOP_LEAD_CYC = link_init_pkg::CYC_1US
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic coldReq,
  input wire logic warmReq,
  input wire logic stopReq,
  output logic busy,
  output logic linkUp,
  link_if.peer_mp link
);
  if (RST_HOLD_CYC <= STOP_LEAD_CYC || RST_HOLD_CYC >= 32768 || TX_W > 32) begin : g_chk
    $error("link_peer_end: reset hold must exceed stop lead and fit 15 bits");
  end

  typedef enum logic [2:0] {S_COLD_PRE, S_COLD_POST, S_WARM, S_RELEASE, S_IDLE} seq_state_e;
  typedef enum logic [1:0] {L_RESET, L_CTL, L_SYNC, L_DONE} lnk_state_e;

  // synchronisers for {reset wire, device ctl, device clk}
  logic [2:0] s1Reg;
  logic [2:0] s2Reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1Reg <= 3'h0;
      s2Reg <= 3'h0;
    end else begin
      s1Reg <= {link.resetN, link.devCtl, link.devClk};
      s2Reg <= s1Reg;
    end
  end

  seq_state_e seq_reg, seq_next;
  lnk_state_e lnk_reg, lnk_next;
  logic [14:0] cnt_reg, cnt_next;
  logic pg_reg, pg_next;
  logic rstOeN_reg, rstOeN_next;
  logic stopN_reg, stopN_next;
  logic [3:0] div_reg, div_next;
  logic clk_reg, clk_next;
  logic ctl_reg, ctl_next;
  logic [31:0] cad_reg, cad_next;
  logic [4:0] bits_reg, bits_next;
  logic devClkPrev_reg, devClkPrev_next;
  logic devCtlSeen_reg, devCtlSeen_next;
  logic tick;
  logic rise;

  assign tick = (div_reg == 4'(link_init_pkg::HALF_BASE - 1));
  assign rise = tick & ~clk_reg;

  always_comb begin
    seq_next = seq_reg;
    lnk_next = lnk_reg;
    cnt_next = cnt_reg + 15'h1;
    pg_next = pg_reg;
    rstOeN_next = rstOeN_reg;
    stopN_next = stopN_reg;
    div_next = tick ? 4'h0 : div_reg + 4'h1;
    clk_next = tick ? ~clk_reg : clk_reg;
    ctl_next = ctl_reg;
    cad_next = cad_reg;
    bits_next = bits_reg;
    devClkPrev_next = s2Reg[0];
    devCtlSeen_next = devCtlSeen_reg | (s2Reg[0] & ~devClkPrev_reg & s2Reg[1]);
    // one set of flops drives both ends, so they see edges together
    unique case (seq_reg) // [R11]
      S_COLD_PRE: begin
        if (cnt_reg == 15'(RST_HOLD_CYC - 1)) begin
          pg_next = 1'b1; // [R6]
          seq_next = S_COLD_POST;
          cnt_next = 15'h0;
        end
      end
      S_COLD_POST, S_WARM: begin
        stopN_next = 1'b1; // [R10]
        if (cnt_reg == 15'(RST_HOLD_CYC - 1)) begin
          rstOeN_next = 1'b1; // [R6] [R9]
          seq_next = S_RELEASE;
        end
      end
      S_RELEASE: begin
        // the device may still be holding the wire; wait for it
        if (s2Reg[2]) begin
          seq_next = S_IDLE; // [R8]
        end
      end
      S_IDLE: begin
        stopN_next = ~(stopReq & lnk_reg == L_DONE) ; // [R10]
        if (coldReq || warmReq) begin
          seq_next = coldReq ? S_COLD_PRE : S_WARM;
          pg_next = ~coldReq;
          rstOeN_next = 1'b0;
          stopN_next = 1'b1;
          cnt_next = 15'h0;
        end
      end
    endcase
    if (seq_reg != S_IDLE) begin
      // transmitter shows its width pattern; unused lanes stay low
      lnk_next = L_RESET;
      ctl_next = 1'b0;
      cad_next = link_init_pkg::adv_pattern(RX_W, TX_W); // [R13] [R14]
      bits_next = 5'h0;
      devCtlSeen_next = 1'b0;
    end else begin
      unique case (lnk_reg)
        L_RESET: begin
          if (rise) begin
            lnk_next = L_CTL;
            ctl_next = 1'b1;
          end
        end
        L_CTL: begin
          if (devCtlSeen_reg) begin
            lnk_next = L_SYNC;
          end
        end
        L_SYNC: begin
          if (tick) begin
            bits_next = bits_reg + 5'h1;
          end
          if (rise && bits_reg >= 5'(link_init_pkg::SYNC_BIT_TIMES)) begin
            lnk_next = L_DONE; // [R23]
            ctl_next = 1'b0;
            cad_next = 32'h0000_0000;
          end
        end
        L_DONE: begin
          lnk_next = L_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seq_reg <= S_COLD_PRE;
      lnk_reg <= L_RESET;
      cnt_reg <= 15'h0;
      pg_reg <= 1'b0;
      rstOeN_reg <= 1'b0;
      stopN_reg <= 1'b1;
      div_reg <= 4'h0;
      clk_reg <= 1'b0;
      ctl_reg <= 1'b0;
      cad_reg <= 32'h0000_0000;
      bits_reg <= 5'h0;
      devClkPrev_reg <= 1'b0;
      devCtlSeen_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      lnk_reg <= lnk_next;
      cnt_reg <= cnt_next;
      pg_reg <= pg_next;
      rstOeN_reg <= rstOeN_next;
      stopN_reg <= stopN_next;
      div_reg <= div_next;
      clk_reg <= clk_next;
      ctl_reg <= ctl_next;
      cad_reg <= cad_next;
      bits_reg <= bits_next;
      devClkPrev_reg <= devClkPrev_next;
      devCtlSeen_reg <= devCtlSeen_next;
    end
  end

  // busy/linkUp are derived from state registers only
  assign busy = (seq_reg != S_IDLE);
  assign linkUp = (lnk_reg == L_DONE);
  assign link.peerClk = clk_reg;
  assign link.peerCtl = ctl_reg;
  assign link.peerCad = cad_reg;
  assign link.sysRstOut = 1'b0;
  assign link.sysRstOeN = rstOeN_reg;
  assign link.powerGood = pg_reg;
  assign link.linkStopN = stopN_reg;
endmodule

// [verif/link_init_asserts.sv]
// checker for the link reset and width advertising, fed from the link wires
// assumes the bench instantiates it beside the interface; sys_clk samples all
`timescale 1ns/1ps
module link_init_asserts #(
  parameter int RST_HOLD = 200,
  parameter int STOP_LEAD = 2,
  parameter logic [31:0] DEV_PAT = 32'h0000_00ff
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic devClk,
  input wire logic devCtl,
  input wire logic [31:0] devCad,
  input wire logic peerCtl,
  input wire logic devRstOeN,
  input wire logic resetN,
  input wire logic powerGood,
  input wire logic linkStopN
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic [15:0] rstLow_reg, rstLow_next, pgHigh_reg, pgHigh_next;
  logic [15:0] stopHigh_reg, stopHigh_next, both_reg, both_next;

  function automatic logic [15:0] sat(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h1;
  endfunction

  // run lengths; cleared by sys_rst, so the reset and power-good thresholds allow two cycles of slack
  always_comb begin
    rstLow_next = resetN ? 16'h0 : sat(rstLow_reg);
    pgHigh_next = powerGood ? sat(pgHigh_reg) : 16'h0;
    stopHigh_next = linkStopN ? sat(stopHigh_reg) : 16'h0;
    both_next = !devCtl ? 16'h0 : (peerCtl ? sat(both_reg) : both_reg); // peer may drop first
  end

  always_ff @(posedge sys_clk) begin
    rstLow_reg <= sys_rst ? 16'h0 : rstLow_next;
    pgHigh_reg <= sys_rst ? 16'h0 : pgHigh_next;
    stopHigh_reg <= sys_rst ? 16'h0 : stopHigh_next;
    both_reg <= sys_rst ? 16'h0 : both_next;
  end

  // pin synchronisers delay the outputs; the cold mark costs one more cycle
  a_ctl_idle_reset: assert property ((!resetN)[*4] |-> !devCtl)
    else $error("control line high during reset");
  a_cold_pattern: assert property ((!resetN && !powerGood)[*5] |-> devCad == DEV_PAT)
    else $error("cold advertising pattern wrong");
  a_pattern_on_ctl: assert property ($rose(devCtl) |-> $stable(devCad) && devCad != 32'h0)
    else $error("pattern dropped when control rose");
  a_cold_clk_rate: assert property ($rose(devClk) && !powerGood && !$past(powerGood, 12)
    |-> devClk[*4] ##1 !devClk)
    else $error("cold reset link clock not at base rate");
  a_sync_invert: assert property ($fell(devCtl) && resetN && linkStopN
    |-> both_reg >= 16'd16 && devCad == 32'h0)
    else $error("sync state left early or data not inverted");
  a_warm_hold: assert property ($rose(resetN) |-> rstLow_reg >= RST_HOLD - 2)
    else $error("reset released too early");
  a_cold_lead: assert property ($rose(powerGood) |-> !resetN && rstLow_reg >= RST_HOLD - 2)
    else $error("power-good rose without reset lead");
  a_cold_tail: assert property ($rose(resetN) |-> pgHigh_reg >= RST_HOLD - 2)
    else $error("reset released too soon after power-good");
  a_stop_lead: assert property ($rose(resetN) |-> stopHigh_reg >= STOP_LEAD)
    else $error("link-stop not high ahead of reset release");
  a_pg_with_reset: assert property ($fell(powerGood) |-> !resetN)
    else $error("power-good dropped without reset");
  a_dev_extend: assert property ($fell(devRstOeN) |-> powerGood && $past(powerGood, 2))
    else $error("device pulled reset before power-good");

  c_warm: cover property ($rose(resetN) && powerGood && pgHigh_reg > rstLow_reg);
  c_sync_done: cover property ($fell(devCtl) && resetN);
  c_extend: cover property ($fell(devRstOeN));
  c_stop: cover property ($fell(linkStopN));
endmodule

// [verif/tb_top.sv]
// bench: device end facing the peer end, plus a device on an unused link
// assumes 20 MHz sys_clk; the peer end starts every main-link reset (the device may stretch it) and makes all link-stop traffic
`timescale 1ns/1ps
module tb_top;
  localparam int HOLD = 200;
  logic sys_clk, sys_rst, clkStable, errEvent, coldReq, warmReq, stopReq;
  logic [5:0] progInWidth, progOutWidth, inWidth, outWidth, inWidthB, nOut, nIn, expOut;
  logic [1:0] progFreq, freqActive, nFreq, expFreq;
  logic chainTerminal, persistErr, unitIdAssign, initDone, busy, linkUp, chainTerminalB;
  int mismatches = 0, n_checks = 0, seed, idPulses = 0, i;
  link_if link(); // one wire set: both ends see reset edges together
  link_if linkB();

  link_dev_end i_link_dev_end (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .progInWidth(progInWidth), .progOutWidth(progOutWidth), .progFreq(progFreq),
    .clkStable(clkStable), .errEvent(errEvent), .inWidth(inWidth), .outWidth(outWidth),
    .freqActive(freqActive), .chainTerminal(chainTerminal), .persistErr(persistErr),
    .unitIdAssign(unitIdAssign), .initDone(initDone), .link(link));
  link_dev_end i_link_dev_end_b (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .progInWidth(progInWidth), .progOutWidth(progOutWidth), .progFreq(progFreq),
    .clkStable(clkStable), .errEvent(errEvent), .inWidth(inWidthB), .outWidth(),
    .freqActive(), .chainTerminal(chainTerminalB), .persistErr(), .unitIdAssign(),
    .initDone(), .link(linkB));
  // a narrower peer transmitter makes the width decode non-trivial
  link_peer_end #(.TX_W(4), .RX_W(8), .RST_HOLD_CYC(HOLD), .STOP_LEAD_CYC(2)) i_link_peer_end (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .coldReq(coldReq), .warmReq(warmReq),
    .stopReq(stopReq), .busy(busy), .linkUp(linkUp), .link(link));
  link_init_asserts #(.RST_HOLD(HOLD), .STOP_LEAD(2), .DEV_PAT(32'h0000_00ff))
    i_link_init_asserts (.sys_clk(sys_clk), .sys_rst(sys_rst), .devClk(link.devClk),
    .devCtl(link.devCtl), .devCad(link.devCad), .peerCtl(link.peerCtl),
    .devRstOeN(link.devRstOeN), .resetN(link.resetN), .powerGood(link.powerGood),
    .linkStopN(link.linkStopN));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // counts release pulses; only cold resets may produce one
  always @(posedge sys_clk) if (unitIdAssign === 1'b1) idPulses <= idPulses + 1;

  function automatic logic [31:0] ones(input logic [5:0] w);
    return (32'h1 << w) - 32'h1;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // bounded wait for both ends to finish sync and invert
  task automatic wait_up();
    int k;
    k = 0;
    while (!(initDone === 1'b1 && linkUp === 1'b1 && busy === 1'b0) && k < 5000) begin
      @(posedge sys_clk);
      k++;
    end
    check("link_up", 32'(k < 5000), 32'h1);
  endtask

  task automatic warm_reset();
    @(posedge sys_clk) warmReq <= 1'b1;
    @(posedge sys_clk) warmReq <= 1'b0;
    repeat (20) @(posedge sys_clk);
    check("warm_pg", link.powerGood, 32'h1);
    check("warm_ctl", link.devCtl, 32'h0);
    check("warm_cad", link.devCad, ones(expOut));
    wait_up();
  endtask

  // main sequence
  initial begin
    seed = 82;
    sys_rst = 1'b1;
    clkStable = 1'b1;
    errEvent = 1'b0;
    coldReq = 1'b0;
    warmReq = 1'b0;
    stopReq = 1'b0;
    progInWidth = 6'h08;
    progOutWidth = 6'h08;
    progFreq = 2'h0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (60) @(posedge sys_clk);
    check("cold_ctl", link.devCtl, 32'h0);
    check("cold_cad", link.devCad, 32'h0000_00ff);
    check("peer_cad", link.peerCad, 32'h0000_000f);
    check("cold_pg", link.powerGood, 32'h0);
    wait_up();
    check("in_w", inWidth, 32'h4);
    check("out_w", outWidth, 32'h4);
    check("in_eq_out", 32'(inWidth == outWidth), 32'h1);
    check("term", chainTerminal, 32'h0);
    check("freq", freqActive, 32'h0);
    check("ids", idPulses, 32'h1);
    expOut = 6'h04;
    expFreq = 2'h0;
    @(posedge sys_clk) errEvent <= 1'b1;
    @(posedge sys_clk) errEvent <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("err_set", persistErr, 32'h1);
    // first pass is the corner: full width at the cold cap, fastest rate
    for (i = 0; i < 4; i++) begin
      nOut = (i == 0) ? 6'h08 : 6'h02 << ($unsigned($random(seed)) % 3);
      nIn = (i == 0) ? 6'h08 : 6'h02 << ($unsigned($random(seed)) % 3);
      nFreq = (i == 0) ? 2'h2 : 2'($unsigned($random(seed)) % 3);
      @(posedge sys_clk);
      progOutWidth <= nOut;
      progInWidth <= nIn;
      progFreq <= nFreq;
      repeat (30) @(posedge sys_clk);
      check("freq_hold", freqActive, expFreq);
      check("outw_hold", outWidth, expOut);
      warm_reset();
      expOut = nOut;
      expFreq = nFreq;
      check("warm_out", outWidth, expOut);
      check("warm_in", inWidth, nIn);
      check("warm_freq", freqActive, expFreq);
      check("warm_term", chainTerminal, 32'h0);
      check("warm_err", persistErr, 32'h1);
      check("warm_ids", idPulses, 32'h1);
    end
    // link-stop also applies a new rate
    @(posedge sys_clk);
    progFreq <= 2'h1;
    stopReq <= 1'b1;
    repeat (12) @(posedge sys_clk);
    check("stop_pin", link.linkStopN, 32'h0);
    check("stop_freq", freqActive, 32'h1);
    @(posedge sys_clk) stopReq <= 1'b0;
    wait_up();
    // cold reset with slow transmit clocks: device stretches the reset wire
    @(posedge sys_clk) coldReq <= 1'b1;
    @(posedge sys_clk) coldReq <= 1'b0;
    // drop clkStable only once power-good is low, else the pull looks premature
    repeat (4) @(posedge sys_clk);
    clkStable <= 1'b0;
    repeat (2 * HOLD + 35) @(posedge sys_clk);
    check("ext_wire", link.resetN, 32'h0);
    check("ext_oe", link.devRstOeN, 32'h0);
    check("ext_cad", link.devCad, 32'h0000_00ff);
    @(posedge sys_clk) clkStable <= 1'b1;
    wait_up();
    check("cold_err", persistErr, 32'h0);
    check("cold_ids", idPulses, 32'h2);
    check("cold_freq", freqActive, 32'h0);
    check("cold_out", outWidth, 32'h4);
    final_report();
  end

  // unused link: clock, control and data inputs of the second device held at 0 by the board
  initial begin
    linkB.peerClk = 1'b0;
    linkB.peerCtl = 1'b0;
    linkB.peerCad = 32'h0;
    linkB.sysRstOut = 1'b0;
    linkB.sysRstOeN = 1'b0;
    linkB.powerGood = 1'b0;
    linkB.linkStopN = 1'b1;
    repeat (20 + HOLD) @(posedge sys_clk);
    linkB.powerGood <= 1'b1;
    repeat (HOLD) @(posedge sys_clk);
    linkB.sysRstOeN <= 1'b1;
    repeat (200) @(posedge sys_clk);
    check("unused_term", chainTerminalB, 32'h1);
    check("unused_w", inWidthB, 32'h2);
    check("unused_ctl", linkB.devCtl, 32'h0);
  end

  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end
endmodule
